// *** common/pattern_timing_defines.vh ***
`ifndef PATTERN_TIMING_DEFINES_VH
`define PATTERN_TIMING_DEFINES_VH
// ==========================================
// page 0 register offsets
`define OFF_CTL 5'h01
`define OFF_CFG 5'h02
`define OFF_CSI_ID 5'h03
`define OFF_LINE_HIGH 5'h04
`define OFF_LINE_LOW 5'h05
`define OFF_BAR_HIGH 5'h06
`define OFF_BAR_LOW 5'h07
`define OFF_ACT_HIGH 5'h08
`define OFF_ACT_LOW 5'h09
`define OFF_TOT_HIGH 5'h0a
`define OFF_TOT_LOW 5'h0b
`define OFF_PD_HIGH 5'h0c
`define OFF_PD_LOW 5'h0d
`define OFF_VBP 5'h0e
`define OFF_VFP 5'h0f
`define OFF_COLOR_BASE 5'h10
// ==========================================
// reset values
`define RST_CTL 8'h00
`define RST_CFG 8'h33
`define RST_CSI_ID 8'h24
`define RST_LINE_HIGH 8'h07
`define RST_LINE_LOW 8'h80
`define RST_BAR_HIGH 8'h00
`define RST_BAR_LOW 8'hf0
`define RST_ACT_HIGH 8'h01
`define RST_ACT_LOW 8'he0
`define RST_TOT_HIGH 8'h02
`define RST_TOT_LOW 8'h0d
`define RST_PD_HIGH 8'h0c
`define RST_PD_LOW 8'h67
`define RST_VBP 8'h21
`define RST_VFP 8'h0a
`define RST_COLOR0 8'haa
`define RST_COLOR1 8'h33
`define RST_COLOR2 8'hf0
`define RST_COLOR3 8'h7f
`define RST_COLOR4 8'h55
`define RST_COLOR5 8'hcc
`define RST_COLOR6 8'h0f
`define RST_COLOR7 8'h80
// ==========================================
// field positions
`define CTL_ON_BIT 0
`define CFG_FIXED_BIT 7
`define CFG_BARS_HI 5
`define CFG_BARS_LO 4
`define CFG_BLOCK_HI 3
`define CFG_BLOCK_LO 0
// ==========================================
// timing: line period unit and clock period, ns
`define PERIOD_UNIT_NS 10
`define CLK_PERIOD_NS 40
// ==========================================
// stream token kinds and output buffer depth
`define KIND_BYTE 2'b00
`define KIND_LAST 2'b01
`define KIND_FS 2'b10
`define KIND_FE 2'b11
`define FIFO_DEPTH 8
`endif

// *** tb/frame_timing_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module frame_timing_asserts (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic stream_valid,
   input wire logic stream_ready,
   input wire logic [1:0] stream_kind,
   input wire logic [7:0] stream_data,
   input wire logic frame_running,
   input wire logic [15:0] line_index
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [15:0] pd_reg, tot_reg, last_reg, cnt_reg;
   logic seen_reg;
   wire ctl_wr = reg_wr && reg_addr == 8'h01;
   wire [19:0] cyc = {4'h0, pd_reg} * 20'h0000a / 20'h00028;
   // ==========
   // shadow of timing registers and line length counter
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         pd_reg <= 16'h0c67;
         tot_reg <= 16'h020d;
         last_reg <= 16'h0;
         cnt_reg <= 16'h0;
         seen_reg <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == 8'h0c) pd_reg[15:8] <= reg_wdata;
         if (reg_wr && reg_addr == 8'h0d) pd_reg[7:0] <= reg_wdata;
         if (reg_wr && reg_addr == 8'h0a) tot_reg[15:8] <= reg_wdata;
         if (reg_wr && reg_addr == 8'h0b) tot_reg[7:0] <= reg_wdata;
         last_reg <= line_index;
         cnt_reg <= (line_index != last_reg) ? 16'h1 : cnt_reg + 16'h1;
         seen_reg <= frame_running && (seen_reg || (line_index != last_reg && line_index != 0));
      end
   end
   AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   AST_RVALID_CAUSE: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("read valid without read");
   AST_UNMAPPED_ZERO: assert property (reg_rd && reg_addr >= 8'h20 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_HOLD: assert property (stream_valid && !stream_ready |=> stream_valid
      && $stable(stream_kind) && $stable(stream_data)) else $error("token not held");
   AST_ENABLE_RUNS: assert property (ctl_wr && reg_wdata[0] |-> ##[1:3] frame_running)
      else $error("enable did not start");
   AST_DISABLE_STOPS: assert property (ctl_wr && !reg_wdata[0] |-> ##[1:3] !frame_running)
      else $error("disable did not stop");
   AST_START_LINE0: assert property ($rose(frame_running) |-> line_index == 16'h0)
      else $error("run not at line 0");
   AST_LINE_PERIOD: assert property (frame_running && seen_reg && line_index != last_reg
      |-> {4'h0, cnt_reg} == cyc) else $error("line period wrong");
   AST_LINE_BOUND: assert property (frame_running |-> line_index < tot_reg)
      else $error("line beyond total");
   cover property (stream_valid && stream_ready && stream_kind == 2'b11);
   cover property (stream_valid && !stream_ready);
   cover property ($fell(frame_running));
endmodule
bind test_pattern_frame_timing frame_timing_asserts i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .stream_valid(stream_valid),
   .stream_ready(stream_ready), .stream_kind(stream_kind), .stream_data(stream_data),
   .frame_running(frame_running), .line_index(line_index));
`default_nettype wire

// *** tb/stream_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
module stream_sink (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic slow,
   output logic stream_ready
);
   integer seed = 32'h0fded2ad;
   // stalls one cycle in two when slow, one in eight otherwise
   always @(posedge ref_clk) begin
      stream_ready <= rst_n && ($random(seed) % (slow ? 2 : 8) != 0);
   end
endmodule
`default_nettype wire

// *** tb/tb_test_pattern_frame_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_test_pattern_frame_timing;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic slow = 1'b0;
   wire [7:0] reg_rdata;
   wire reg_rvalid, stream_valid, stream_ready, frame_running;
   wire [1:0] stream_kind;
   wire [7:0] stream_data;
   wire [15:0] line_index;
   integer num_errors = 0;
   integer num_checks = 0;
   integer seed = 32'h0fded2ad;
   logic [9:0] tok[$];
   logic [9:0] lin[$];
   logic [7:0] v;
   logic [7:0] mem [0:31];
   logic [7:0] pg [2:15];
   logic [7:0] rst_tab [1:15] = '{8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00, 8'hf0, 8'h01,
      8'he0, 8'h02, 8'h0d, 8'h0c, 8'h67, 8'h21, 8'h0a};
   int len, w, nb, n;
   always #20 ref_clk = ~ref_clk;
   test_pattern_frame_timing i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .stream_valid(stream_valid), .stream_ready(stream_ready),
      .stream_kind(stream_kind), .stream_data(stream_data), .frame_running(frame_running),
      .line_index(line_index));
   stream_sink i_sink (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
      .stream_ready(stream_ready));
   always @(posedge ref_clk) begin
      if (stream_valid && stream_ready) begin
         tok.push_back({stream_kind, stream_data});
         lin.push_back(line_index[9:0]);
      end
   end
   // ==========
   // tasks
   task results;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      chk("read valid", 10'h1, {9'h0, reg_rvalid});
   endtask
   task await_tok(input int cnt);
      int t;
      t = 0;
      while (tok.size() < cnt && t < 3000) begin
         @(posedge ref_clk);
         t++;
      end
      if (tok.size() < cnt) begin
         chk("token count", cnt[9:0], tok.size());
         results();
      end
   endtask
   function automatic logic [7:0] exp_byte(input int i, input int bw, input int bars, input bit fx);
      int b;
      b = fx ? i % 3 : (i / bw < bars ? i / bw : bars - 1);
      return mem[16 + b];
   endfunction
   // ==========
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int a = 1; a < 16; a++) begin
         rd(a[7:0], v);
         chk("reset value", {2'b00, rst_tab[a]}, {2'b00, v});
      end
      for (int a = 0; a < 34; a++) begin
         n = $random(seed);
         if (a < 32) mem[a] = n[7:0];
         if (a != 1) wr(a[7:0], n[7:0]);
         if (a != 1) rd(a[7:0], v);
         if (a != 1) chk("read back", (a == 0 || a > 31) ? 10'h0 : {2'b00, n[7:0]}, {2'b00, v});
      end
      for (int k = 0; k < 5; k++) begin
         len = 9 + ($random(seed) & 15);
         w = 2 + ($random(seed) & 3);
         nb = 1 << k;
         slow <= k[0];
         pg = '{{k == 4, 1'b0, k[1:0], 4'h3}, 8'h24, 8'h00, len[7:0], 8'h00, w[7:0], 8'h00,
            8'h02, 8'h00, 8'h06, 8'h01, 8'h90, 8'h01, 8'h01};
         for (int a = 2; a < 16; a++) wr(a[7:0], pg[a]);
         wr(8'h01, 8'h01);
         // line length changed mid-frame must not reach the running frame
         wr(8'h05, len[7:0] + 8'h05);
         await_tok(3 + 2 * len);
         chk("frame start", 10'h200, tok[0]);
         chk("first video line", {2'b00, pg[14]} + 10'h001, lin[1]);
         chk("frame end line", {2'b00, pg[14]} + {2'b00, pg[9]} + {2'b00, pg[15]} + 10'h001,
            lin[1 + 2 * len]);
         for (int l = 0; l < 2; l++) begin
            for (int i = 0; i < len; i++) begin
               chk("pixel", {i == len - 1 ? 2'b01 : 2'b00, exp_byte(i, w, nb, k == 4)}, tok[1 + l * len + i]);
            end
         end
         chk("frame end", 10'h300, tok[1 + 2 * len]);
         chk("next frame", 10'h200, tok[2 + 2 * len]);
         wr(8'h01, 8'h00);
         repeat (40) @(posedge ref_clk);
         #1 chk("stopped", 10'h0, {8'h0, frame_running, stream_valid});
         tok.delete();
         lin.delete();
      end
      results();
   end
endmodule
`default_nettype wire

// *** verilog/test_pattern_frame_timing.v ***
// Function
// - active line length in bytes from two byte registers, reset 0x0780.
// - bar width in bytes from two byte registers, reset 0x00f0.
// - programmed bar width applies to every bar except the last.
// - last bar runs on to the end of the active line.
// - active lines per frame from two byte registers, reset 480.
// - total lines per frame including blanking, reset 0x020d.
// - line period in 10 ns units, reset 0x0c67 gives 31.75 us.
// - back-porch blank lines between frame start and first video line.
// - front-porch blank lines between last video line and frame end.
// - generator runs only while enable bit is one; resets to zero.
// - pattern select zero gives colour bars, one gives fixed pattern.
// - bar count code 00/01/10/11 gives 1/2/4/8 bars.
// - bar N sends colour N; fixed mode sends colours in sequence.
`timescale 1ns/1ps
`default_nettype none
`include "pattern_timing_defines.vh"

module pattern_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire ref_clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr_reg;
   reg [AW:0] rd_ptr_reg;
   wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
      (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   wire empty = (wr_ptr_reg == rd_ptr_reg);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (out_ready && !empty)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
endmodule

module test_pattern_frame_timing (
   input wire ref_clk,
   input wire rst_n,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg reg_rvalid,
   output wire stream_valid,
   input wire stream_ready,
   output wire [1:0] stream_kind,
   output wire [7:0] stream_data,
   output reg frame_running,
   output reg [15:0] line_index
);
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   // ==========================================
   // register file, page 0 offsets 0x00-0x1f
   reg [7:0] regs [0:31];
   wire page_hit = (reg_addr[7:5] == 3'b000);
   integer i;

   function [7:0] reset_value;
      input [4:0] a;
      begin
         case (a)
            `OFF_CTL: reset_value = `RST_CTL;
            `OFF_CFG: reset_value = `RST_CFG;
            `OFF_CSI_ID: reset_value = `RST_CSI_ID;
            `OFF_LINE_HIGH: reset_value = `RST_LINE_HIGH;
            `OFF_LINE_LOW: reset_value = `RST_LINE_LOW;
            `OFF_BAR_HIGH: reset_value = `RST_BAR_HIGH;
            `OFF_BAR_LOW: reset_value = `RST_BAR_LOW;
            `OFF_ACT_HIGH: reset_value = `RST_ACT_HIGH;
            `OFF_ACT_LOW: reset_value = `RST_ACT_LOW;
            `OFF_TOT_HIGH: reset_value = `RST_TOT_HIGH;
            `OFF_TOT_LOW: reset_value = `RST_TOT_LOW;
            `OFF_PD_HIGH: reset_value = `RST_PD_HIGH;
            `OFF_PD_LOW: reset_value = `RST_PD_LOW;
            `OFF_VBP: reset_value = `RST_VBP;
            `OFF_VFP: reset_value = `RST_VFP;
            5'h10: reset_value = `RST_COLOR0;
            5'h11: reset_value = `RST_COLOR1;
            5'h12: reset_value = `RST_COLOR2;
            5'h13: reset_value = `RST_COLOR3;
            5'h14: reset_value = `RST_COLOR4;
            5'h15: reset_value = `RST_COLOR5;
            5'h16: reset_value = `RST_COLOR6;
            5'h17: reset_value = `RST_COLOR7;
            default: reset_value = 8'h00;
         endcase
      end
   endfunction

   function [15:0] pair;
      input [7:0] hi;
      input [7:0] lo;
      begin
         pair = {hi, lo};
      end
   endfunction

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         for (i = 0; i < 32; i = i + 1)
            regs[i] <= reset_value(i[4:0]);
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         if (reg_wr && page_hit && reg_addr[4:0] != 5'h00)
            regs[reg_addr[4:0]] <= reg_wdata;
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= page_hit ? regs[reg_addr[4:0]] : 8'h00;
      end
   end

   wire generator_on = regs[`OFF_CTL][`CTL_ON_BIT];
   wire fixed_pattern_select = regs[`OFF_CFG][`CFG_FIXED_BIT];
   wire [1:0] bar_count_code = regs[`OFF_CFG][`CFG_BARS_HI:`CFG_BARS_LO];
   wire [3:0] block_size = regs[`OFF_CFG][`CFG_BLOCK_HI:`CFG_BLOCK_LO];

   // ==========================================
   // frame-coherent copies of the timing values
   reg [15:0] active_line_bytes;
   reg [15:0] bar_width_bytes;
   reg [15:0] active_line_count;
   reg [15:0] frame_line_count;
   reg [15:0] line_period_count;
   reg [7:0] vertical_back_blank_lines;
   reg [7:0] vertical_front_blank_lines;

   // line cycles = period * 10 ns / 40 ns, at least one
   wire [31:0] period_ns = line_period_count * `PERIOD_UNIT_NS;
   wire [31:0] cycles_raw = period_ns / `CLK_PERIOD_NS;
   wire [15:0] line_cycles = (cycles_raw == 32'h00000000) ? 16'h0001 : cycles_raw[15:0];

   wire [16:0] first_active = {9'h000, vertical_back_blank_lines} + 17'h00001;
   wire [16:0] after_active = first_active + {1'b0, active_line_count};
   wire [16:0] fe_line = after_active + {9'h000, vertical_front_blank_lines};

   // ==========================================
   // line and frame sequencing
   reg state_reg;
   reg [15:0] cyc_cnt;
   reg fs_pend;
   reg fe_pend;
   reg [15:0] bytes_left;
   reg [15:0] bar_pos;
   reg [2:0] bar_idx;
   reg [3:0] fix_idx;
   wire fifo_ready;
   reg push;
   reg [9:0] push_word;

   wire [2:0] last_bar = (3'b001 << bar_count_code) - 3'b001;
   wire [3:0] block_last = (block_size == 4'h0) ? 4'h0 : block_size - 4'h1;
   wire line_end = (cyc_cnt >= line_cycles - 16'h0001);
   wire [15:0] line_next = line_index + 16'h0001;
   wire frame_wrap = (line_next >= frame_line_count);
   wire [7:0] pixel = fixed_pattern_select ? regs[{1'b1, fix_idx}] :
      regs[{2'b10, bar_idx}];

   always @* begin
      push = 1'b0;
      push_word = {`KIND_BYTE, 8'h00};
      if (state_reg == ST_RUN) begin
         if (fs_pend) begin
            push = 1'b1;
            push_word = {`KIND_FS, 8'h00};
         end else if (bytes_left != 16'h0000) begin
            push = 1'b1;
            push_word = {(bytes_left == 16'h0001) ? `KIND_LAST : `KIND_BYTE, pixel};
         end else if (fe_pend) begin
            push = 1'b1;
            push_word = {`KIND_FE, 8'h00};
         end
      end
   end

   wire pushed = push && fifo_ready;

   task latch_timing;
      begin
         active_line_bytes <= pair(regs[`OFF_LINE_HIGH], regs[`OFF_LINE_LOW]);
         bar_width_bytes <= pair(regs[`OFF_BAR_HIGH], regs[`OFF_BAR_LOW]);
         active_line_count <= pair(regs[`OFF_ACT_HIGH], regs[`OFF_ACT_LOW]);
         frame_line_count <= pair(regs[`OFF_TOT_HIGH], regs[`OFF_TOT_LOW]);
         line_period_count <= pair(regs[`OFF_PD_HIGH], regs[`OFF_PD_LOW]);
         vertical_back_blank_lines <= regs[`OFF_VBP];
         vertical_front_blank_lines <= regs[`OFF_VFP];
      end
   endtask

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         frame_running <= 1'b0;
         line_index <= 16'h0000;
         cyc_cnt <= 16'h0000;
         fs_pend <= 1'b0;
         fe_pend <= 1'b0;
         bytes_left <= 16'h0000;
         bar_pos <= 16'h0000;
         bar_idx <= 3'h0;
         fix_idx <= 4'h0;
         active_line_bytes <= {`RST_LINE_HIGH, `RST_LINE_LOW};
         bar_width_bytes <= {`RST_BAR_HIGH, `RST_BAR_LOW};
         active_line_count <= {`RST_ACT_HIGH, `RST_ACT_LOW};
         frame_line_count <= {`RST_TOT_HIGH, `RST_TOT_LOW};
         line_period_count <= {`RST_PD_HIGH, `RST_PD_LOW};
         vertical_back_blank_lines <= `RST_VBP;
         vertical_front_blank_lines <= `RST_VFP;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (generator_on) begin
                  latch_timing;
                  state_reg <= ST_RUN;
                  frame_running <= 1'b1;
                  line_index <= 16'h0000;
                  cyc_cnt <= 16'h0000;
                  fs_pend <= 1'b1;
               end
            end
            ST_RUN: begin
               if (!generator_on) begin
                  state_reg <= ST_IDLE;
                  frame_running <= 1'b0;
                  fs_pend <= 1'b0;
                  fe_pend <= 1'b0;
                  bytes_left <= 16'h0000;
               end else begin
                  // byte and bar stepping
                  if (pushed && fs_pend)
                     fs_pend <= 1'b0;
                  else if (pushed && bytes_left != 16'h0000) begin
                     bytes_left <= bytes_left - 16'h0001;
                     fix_idx <= (fix_idx >= block_last) ? 4'h0 : fix_idx + 4'h1;
                     if (bar_idx != last_bar &&
                        bar_pos >= bar_width_bytes - 16'h0001) begin
                        bar_idx <= bar_idx + 3'h1;
                        bar_pos <= 16'h0000;
                     end else begin
                        bar_pos <= bar_pos + 16'h0001;
                     end
                  end else if (pushed && fe_pend)
                     fe_pend <= 1'b0;
                  if (line_end) begin
                     cyc_cnt <= 16'h0000;
                     bar_pos <= 16'h0000;
                     bar_idx <= 3'h0;
                     fix_idx <= 4'h0;
                     bytes_left <= 16'h0000;
                     if (frame_wrap) begin
                        line_index <= 16'h0000;
                        latch_timing;
                        fs_pend <= 1'b1;
                     end else begin
                        line_index <= line_next;
                        if ({1'b0, line_next} >= first_active &&
                           {1'b0, line_next} < after_active)
                           bytes_left <= active_line_bytes;
                        if ({1'b0, line_next} == fe_line)
                           fe_pend <= 1'b1;
                     end
                  end else begin
                     cyc_cnt <= cyc_cnt + 16'h0001;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // output buffer
   pattern_fifo #(
      .WIDTH(10),
      .DEPTH(`FIFO_DEPTH),
      .AW(3)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(push_word),
      .out_valid(stream_valid),
      .out_ready(stream_ready),
      .out_data({stream_kind, stream_data})
   );
endmodule

`default_nettype wire
